// [logic/fsp_pkg.sv]
// package: register map, field layout and shared types of the flash self-program control
package fsp_pkg;

	// register offsets
	localparam logic [7:0] FSP_OFS_STATUS = 8'hEB;
	localparam logic [7:0] FSP_OFS_SECT_HIGH = 8'hEC;
	localparam logic [7:0] FSP_OFS_SECT_LOW = 8'hED;
	localparam logic [7:0] FSP_OFS_UNLOCK = 8'hEE;
	localparam logic [7:0] FSP_OFS_OP_CTRL = 8'hEF;

	// reset values
	localparam logic [7:0] FSP_RST_SECT_HIGH = 8'h00;
	localparam logic [7:0] FSP_RST_SECT_LOW = 8'h00;
	localparam logic [7:0] FSP_RST_UNLOCK = 8'h00;
	localparam logic [3:0] FSP_RST_MODE = 4'h0;

	// unlock key
	localparam logic [7:0] FSP_UNLOCK_KEY = 8'hA5;

	// operation control fields
	localparam int FSP_MODE_MSB = 7;
	localparam int FSP_MODE_LSB = 4;
	localparam int FSP_START_BIT = 0;
	localparam logic [3:0] FSP_MODE_PROG = 4'h5;
	localparam logic [3:0] FSP_MODE_ERASE = 4'hA;
	localparam logic [3:0] FSP_MODE_LOCK = 4'h6;

	// status fields
	localparam int FSP_ST_BUSY_BIT = 0;
	localparam int FSP_ST_UNLOCK_BIT = 1;
	localparam int FSP_ST_REFUSED_BIT = 2;
	localparam int FSP_ST_PROG_BIT = 3;

	typedef enum logic [1:0] {
		FSP_OP_NONE,
		FSP_OP_PROG,
		FSP_OP_ERASE,
		FSP_OP_LOCK
	} fsp_op_t;

	typedef enum logic [0:0] {
		FSP_IDLE,
		FSP_RUN
	} fsp_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} fsp_bus_t;

	typedef struct packed {
		logic start;
		fsp_op_t op;
		logic [15:0] sector;
	} fsp_flash_req_t;

endpackage

// [logic/fsp_op_decode.sv]
// operation decoder: mode nibble to operation kind and start permission
`timescale 1ns/1ps
`default_nettype none
module fsp_op_decode
	import fsp_pkg::*;
(
	// request
	input wire logic [3:0] i_mode,
	input wire logic i_unlocked,
	// decision
	output fsp_op_t o_op,
	output logic o_can_start
);

	always_comb begin
		unique case (i_mode)
			FSP_MODE_PROG: o_op = FSP_OP_PROG; // RL7
			FSP_MODE_ERASE: o_op = FSP_OP_ERASE; // RL7
			FSP_MODE_LOCK: o_op = FSP_OP_LOCK; // RL7
			default: o_op = FSP_OP_NONE;
		endcase
		// programming is driven by the core per byte, so only erase and lock
		// use the start bit; everything needs the key at the moment of start
		o_can_start = i_unlocked && (o_op == FSP_OP_ERASE || o_op == FSP_OP_LOCK); // RL8
	end

endmodule
`default_nettype wire

// [logic/fsp_flash_ctrl.sv]
// flash self-program control registers: sector pointer, unlock key, operation launch
//
// Function
// RL1: the sector pointer is 16 bits, low register gives bits 7..0 and high register bits 15..8.
// RL2: the low sector register sits at EDh, is fully read/write and resets to zero.
// RL3: the high sector register sits at ECh and holds the upper half of the pointer.
// RL4: user programming is enabled only while the unlock register at EEh holds A5h.
// RL5: any other unlock value keeps programming and flash operations off, and it resets to zero.
// RL6: these registers are reached only by direct register accesses in the selected bank.
// RL7: the control upper nibble picks the operation: 0101 program, 1010 erase, one code hard lock.
// RL8: a start request is ignored unless the unlock register holds the key when it is made.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_ctrl
	import fsp_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// register port
	input wire fsp_bus_t i_bus,
	input wire logic i_bank1,
	output logic [7:0] o_rdata,
	// flash macro
	output fsp_flash_req_t o_flash,
	input wire logic i_flash_done,
	// status
	output logic [15:0] o_sector,
	output logic o_unlocked,
	output logic o_prog_enable,
	output logic o_busy
);

	typedef struct packed {
		logic [7:0] sect_high;
		logic [7:0] sect_low;
		logic [7:0] unlock;
		logic [3:0] mode;
		logic start;
		logic refused;
		fsp_state_t fsm;
		logic [7:0] rdata;
		fsp_flash_req_t flash;
		logic unlocked;
		logic prog_en;
		logic busy;
	} fsp_regs_t;

	fsp_regs_t r;
	fsp_regs_t next_r;

	logic sel;
	logic wr_status;
	logic wr_high;
	logic wr_low;
	logic wr_unlock;
	logic wr_ctrl;
	logic key_ok;
	fsp_op_t dec_op;
	logic dec_can_start;
	logic [7:0] status_word;
	logic [7:0] ctrl_word;

	// only direct accesses in bank 1 arrive here; others are not decoded
	assign sel = i_bank1; // RL6
	assign wr_status = sel && i_bus.wr && i_bus.addr == FSP_OFS_STATUS;
	assign wr_high = sel && i_bus.wr && i_bus.addr == FSP_OFS_SECT_HIGH;
	assign wr_low = sel && i_bus.wr && i_bus.addr == FSP_OFS_SECT_LOW;
	assign wr_unlock = sel && i_bus.wr && i_bus.addr == FSP_OFS_UNLOCK;
	assign wr_ctrl = sel && i_bus.wr && i_bus.addr == FSP_OFS_OP_CTRL;

	// the key seen now, before this cycle's write lands
	assign key_ok = r.unlock == FSP_UNLOCK_KEY; // RL8

	fsp_op_decode u_decode (
		.i_mode(i_bus.wdata[FSP_MODE_MSB:FSP_MODE_LSB]),
		.i_unlocked(key_ok),
		.o_op(dec_op),
		.o_can_start(dec_can_start)
	);

	always_comb begin
		status_word = 8'h00;
		status_word[FSP_ST_BUSY_BIT] = r.busy;
		status_word[FSP_ST_UNLOCK_BIT] = r.unlocked;
		status_word[FSP_ST_REFUSED_BIT] = r.refused;
		status_word[FSP_ST_PROG_BIT] = r.prog_en;
		ctrl_word = 8'h00;
		ctrl_word[FSP_MODE_MSB:FSP_MODE_LSB] = r.mode;
		ctrl_word[FSP_START_BIT] = r.start;
	end

	always_comb begin
		next_r = r;
		next_r.flash.start = 1'b0;
		next_r.rdata = 8'h00;

		if (wr_high) begin
			next_r.sect_high = i_bus.wdata; // RL3
		end
		if (wr_low) begin
			next_r.sect_low = i_bus.wdata; // RL2
		end
		if (wr_unlock) begin
			next_r.unlock = i_bus.wdata;
		end
		if (wr_status && i_bus.wdata[FSP_ST_REFUSED_BIT]) begin
			next_r.refused = 1'b0;
		end

		unique case (r.fsm)
			FSP_IDLE: begin
				if (wr_ctrl) begin
					next_r.mode = i_bus.wdata[FSP_MODE_MSB:FSP_MODE_LSB];
					if (i_bus.wdata[FSP_START_BIT]) begin
						if (dec_can_start) begin
							next_r.start = 1'b1;
							next_r.fsm = FSP_RUN;
							next_r.flash.start = 1'b1;
							next_r.flash.op = dec_op;
							next_r.flash.sector = {r.sect_high, r.sect_low}; // RL1
						end else begin
							// ignored request leaves a sticky trace
							next_r.refused = 1'b1; // RL8
						end
					end
				end
			end
			FSP_RUN: begin
				// mode stays frozen while the macro works on the latched op
				if (wr_ctrl && i_bus.wdata[FSP_START_BIT]) begin
					next_r.refused = 1'b1;
				end
				if (i_flash_done) begin
					next_r.start = 1'b0;
					next_r.fsm = FSP_IDLE;
				end
			end
		endcase

		// a refusal in the same cycle as a clear still stands
		if (wr_status && i_bus.wdata[FSP_ST_REFUSED_BIT] && !next_r.refused) begin
			next_r.refused = 1'b0;
		end

		next_r.unlocked = next_r.unlock == FSP_UNLOCK_KEY; // RL4 RL5
		next_r.prog_en = next_r.unlocked && next_r.mode == FSP_MODE_PROG; // RL4 RL5 RL7
		// busy gets its own flop so the output port carries no decode logic
		next_r.busy = next_r.fsm == FSP_RUN;

		if (sel && i_bus.rd) begin
			unique case (i_bus.addr)
				FSP_OFS_STATUS: next_r.rdata = status_word;
				FSP_OFS_SECT_HIGH: next_r.rdata = r.sect_high;
				FSP_OFS_SECT_LOW: next_r.rdata = r.sect_low;
				FSP_OFS_UNLOCK: next_r.rdata = r.unlock;
				FSP_OFS_OP_CTRL: next_r.rdata = ctrl_word;
				default: next_r.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			r.sect_high <= FSP_RST_SECT_HIGH;
			r.sect_low <= FSP_RST_SECT_LOW; // RL2
			r.unlock <= FSP_RST_UNLOCK; // RL5
			r.mode <= FSP_RST_MODE;
			r.start <= 1'b0;
			r.refused <= 1'b0;
			r.fsm <= FSP_IDLE;
			r.rdata <= 8'h00;
			r.flash <= '0;
			r.unlocked <= 1'b0;
			r.prog_en <= 1'b0;
			r.busy <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	assign o_rdata = r.rdata;
	assign o_flash = r.flash;
	assign o_sector = {r.sect_high, r.sect_low}; // RL1
	assign o_unlocked = r.unlocked;
	assign o_prog_enable = r.prog_en;
	assign o_busy = r.busy;

endmodule
`default_nettype wire

// [test/fsp_flash_ctrl_props.sv]
// checker: port properties of the flash self-program control
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_ctrl_chk
	import fsp_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// inputs
	input wire fsp_bus_t i_bus,
	input wire logic i_bank1,
	input wire logic i_flash_done,
	// outputs
	input wire logic [7:0] o_rdata,
	input wire fsp_flash_req_t o_flash,
	input wire logic [15:0] o_sector,
	input wire logic o_unlocked,
	input wire logic o_prog_enable,
	input wire logic o_busy
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	sequence wr_at(logic [7:0] a);
		i_bus.wr && i_bank1 && i_bus.addr == a;
	endsequence
	sequence erase_go;
		i_bus.wr && i_bank1 && i_bus.addr == FSP_OFS_OP_CTRL
			&& i_bus.wdata == 8'hA1 && o_unlocked && !o_busy;
	endsequence
	a_low_write: assert property (wr_at(FSP_OFS_SECT_LOW) |=>
		o_sector[7:0] == $past(i_bus.wdata)) else $error("low byte lost");
	a_high_write: assert property (wr_at(FSP_OFS_SECT_HIGH) |=>
		o_sector[15:8] == $past(i_bus.wdata)) else $error("high byte lost");
	a_unlock_key: assert property (wr_at(FSP_OFS_UNLOCK) |=>
		o_unlocked == ($past(i_bus.wdata) == 8'hA5)) else $error("bad unlock");
	a_locked_nostart: assert property (!o_unlocked |=> !o_flash.start)
		else $error("start while locked");
	a_prog_needs_key: assert property (o_prog_enable |-> o_unlocked)
		else $error("prog without key");
	a_erase_launch: assert property (erase_go |=> o_flash.start && o_busy
		&& o_flash.op == FSP_OP_ERASE && o_flash.sector == $past(o_sector))
		else $error("erase not launched");
	a_bank_gate: assert property (i_bus.wr && !i_bank1 |=>
		$stable(o_sector) && $stable(o_unlocked)) else $error("bank0 write");
	a_read_low: assert property (i_bus.rd && i_bank1 && i_bus.addr ==
		FSP_OFS_SECT_LOW |=> o_rdata == $past(o_sector[7:0]))
		else $error("low read wrong");
	a_start_pulse: assert property (o_flash.start |=> (!o_flash.start)[*2])
		else $error("start too long");
endmodule
bind fsp_flash_ctrl fsp_flash_ctrl_chk chk (.i_core_clk, .i_rst, .i_bus,
	.i_bank1, .i_flash_done, .o_rdata, .o_flash, .o_sector, .o_unlocked,
	.o_prog_enable, .o_busy);
`default_nettype wire

// [test/tb_fsp_flash_ctrl.sv]
// testbench: register scenarios for the flash self-program control
`timescale 1ns/1ps
`default_nettype none
module tb_fsp_flash_ctrl
	import fsp_pkg::*;
;
	logic i_core_clk = 0, i_rst = 1, i_bank1 = 1, i_flash_done = 0;
	fsp_bus_t i_bus = '0;
	logic [7:0] o_rdata;
	fsp_flash_req_t o_flash;
	logic [15:0] o_sector;
	logic o_unlocked, o_prog_enable, o_busy;
	int failures = 0, comparisons = 0;
	always #2.5 i_core_clk = ~i_core_clk;
	fsp_flash_ctrl dut (.i_core_clk, .i_rst, .i_bus, .i_bank1, .o_rdata,
		.o_flash, .i_flash_done, .o_sector, .o_unlocked, .o_prog_enable,
		.o_busy);
	task ck(string n, logic [15:0] s, logic [15:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	// strobe is dropped one edge later so back-to-back calls never collide
	task wr(logic [7:0] a, logic [7:0] d);
		@(posedge i_core_clk) i_bus <= {a, d, 2'b10};
		@(posedge i_core_clk) i_bus.wr <= 0;
		#1;
	endtask
	task rd(logic [7:0] a, logic [7:0] e);
		@(posedge i_core_clk) i_bus <= {a, 8'h00, 2'b01};
		@(posedge i_core_clk) i_bus.rd <= 0;
		#1 ck("rdata", o_rdata, e);
	endtask
	task fin;
		@(posedge i_core_clk) i_flash_done <= 1;
		@(posedge i_core_clk) i_flash_done <= 0;
		#1 ck("busy", o_busy, 0);
	endtask
	task end_of_test;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#20000 failures++;
		end_of_test;
	end
	initial begin
		repeat (3) @(posedge i_core_clk);
		i_rst <= 0;
		rd(FSP_OFS_SECT_HIGH, 8'h00);
		rd(FSP_OFS_SECT_LOW, 8'h00);
		rd(FSP_OFS_UNLOCK, 8'h00);
		wr(FSP_OFS_SECT_LOW, 8'h3C);
		wr(FSP_OFS_SECT_HIGH, 8'hA7);
		ck("sector", o_sector, 16'hA73C);
		rd(FSP_OFS_SECT_LOW, 8'h3C);
		@(posedge i_core_clk) i_bank1 <= 0;
		wr(FSP_OFS_SECT_LOW, 8'hFF);
		@(posedge i_core_clk) i_bank1 <= 1;
		rd(FSP_OFS_SECT_LOW, 8'h3C);
		rd(8'h10, 8'h00);
		wr(FSP_OFS_UNLOCK, 8'hA4);
		ck("unlocked", o_unlocked, 0);
		wr(FSP_OFS_OP_CTRL, 8'hA1);
		ck("busy", o_busy, 0);
		rd(FSP_OFS_STATUS, 8'h04);
		wr(FSP_OFS_STATUS, 8'h04);
		rd(FSP_OFS_STATUS, 8'h00);
		wr(FSP_OFS_UNLOCK, 8'hA5);
		ck("unlocked", o_unlocked, 1);
		wr(FSP_OFS_OP_CTRL, 8'h51);
		ck("prog", o_prog_enable, 1);
		wr(FSP_OFS_OP_CTRL, 8'hA1);
		ck("start", o_flash.start, 1);
		ck("op", o_flash.op, FSP_OP_ERASE);
		ck("fsect", o_flash.sector, 16'hA73C);
		ck("busy", o_busy, 1);
		rd(FSP_OFS_OP_CTRL, 8'hA1);
		fin;
		wr(FSP_OFS_OP_CTRL, 8'h61);
		ck("op", o_flash.op, FSP_OP_LOCK);
		fin;
		wr(FSP_OFS_OP_CTRL, 8'h50);
		ck("prog", o_prog_enable, 1);
		wr(FSP_OFS_UNLOCK, 8'h00);
		ck("unlocked", o_unlocked, 0);
		ck("prog", o_prog_enable, 0);
		wr(FSP_OFS_UNLOCK, 8'hA5);
		// reset while idle must clear the key and the pointer again
		@(posedge i_core_clk) i_rst <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		i_rst <= 1'b0;
		#1 ck("sector", o_sector, 16'h0000);
		ck("unlocked", o_unlocked, 0);
		ck("prog", o_prog_enable, 0);
		rd(FSP_OFS_UNLOCK, 8'h00);
		end_of_test;
	end
endmodule
`default_nettype wire
